// ==== core/reload_timer_core.sv ====
// Function
// - Two independent 16-bit up-counting timers
// - Prescaler divides system clock 1 to 128
// - Count wraps FFFF to 0000 and continues
// - Reload 0001, prescale 1 gives shortest time-out
// - Reload 0000, prescale 128 gives longest
// - One-shot: interrupt, count 0001, disable, halt
// - One-shot output inverts one clock at reload
// - Clocked modes ignore the input pin
// - Continuous: interrupt, count 0001, keep counting
// - Continuous/counter output toggles at each reload
// - Start count affects first pass only
// - Counter mode counts selected input edges
// - Counter mode bypasses prescaler
// - Counter polarity sets initial output level
//
// Register front and two timer channels.
// Assumes a synchronous strobe master; read data valid one cycle after strobe.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
module reload_timer_core
    import reload_timer_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Timer pins
    input wire logic [NUM_TIMERS-1:0] timer_in,
    output logic [NUM_TIMERS-1:0] timer_out,
    output logic [NUM_TIMERS-1:0] timer_irq
);
    // =========================================================
    // Shared state
    logic [DATA_W-1:0] rdata_r, rdata_nxt;    // Read data register
    logic [NUM_TIMERS-1:0] tout_r, tout_nxt;  // Registered pin outputs
    logic [NUM_TIMERS-1:0] irq_r, irq_nxt;    // Registered event pulses
    logic [15:0] ctrl_view [NUM_TIMERS];
    logic [15:0] cnt_view [NUM_TIMERS];
    logic [15:0] rel_view [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] flag_view;
    logic [NUM_TIMERS-1:0] tout_view, exp_view;
    logic sel;

    assign sel = reg_addr[TSEL_BIT];

    // =========================================================
    // Per-timer registers and channel
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : gen_tmr
            timer_ctrl_if ctl ();
            logic [15:0] ctrl_r, ctrl_nxt;    // Control register
            logic [15:0] rel_r, rel_nxt;      // Reload register
            logic flag_r, flag_nxt;           // Sticky reload-seen flag
            logic hit_me, wr_ctrl, rd_stat;

            // Decode for this timer
            always_comb begin
                hit_me = (sel == 1'(g));
                wr_ctrl = reg_wr && hit_me && reg_addr[1:0] == REG_CTRL;
                rd_stat = reg_rd && hit_me && reg_addr[1:0] == REG_STATUS;
                ctrl_nxt = ctrl_r;
                rel_nxt = rel_r;
                flag_nxt = flag_r;
                if (wr_ctrl) begin
                    ctrl_nxt = reg_wdata;
                end
                if (reg_wr && hit_me && reg_addr[1:0] == REG_RELOAD) begin
                    rel_nxt = reg_wdata;
                end
                // Reading status clears; a new event wins over the clear
                if (rd_stat) begin
                    flag_nxt = 1'b0;
                end
                if (ctl.expire) begin
                    flag_nxt = 1'b1;
                    if (ctrl_r[CTRL_MODE_LSB +: 2] == MODE_ONE_SHOT && !wr_ctrl) begin
                        ctrl_nxt[CTRL_EN_BIT] = 1'b0;  // Self-disable
                    end
                end
            end

            // Register the per-timer state
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    ctrl_r <= CTRL_RESET;
                    rel_r <= RELOAD_RESET;
                    flag_r <= 1'b0;
                end else begin
                    ctrl_r <= ctrl_nxt;
                    rel_r <= rel_nxt;
                    flag_r <= flag_nxt;
                end
            end

            // Fields into the channel; a one-shot expire pulse stops it in the same cycle
            assign ctl.enable = ctrl_r[CTRL_EN_BIT] && !(ctl.expire &&
                ctrl_r[CTRL_MODE_LSB +: 2] == MODE_ONE_SHOT);
            assign ctl.mode = ctrl_r[CTRL_MODE_LSB +: 2];
            assign ctl.pol = ctrl_r[CTRL_POL_BIT];
            assign ctl.out_en = ctrl_r[CTRL_OUTEN_BIT];
            assign ctl.pre_sel = ctrl_r[CTRL_PRE_LSB +: PRE_W];
            assign ctl.reload = rel_r;
            assign ctl.count_wr = reg_wr && hit_me && reg_addr[1:0] == REG_COUNT;
            assign ctl.count_wdata = reg_wdata;

            timer_channel u_chan (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .timer_in(timer_in[g]),
                .ctl(ctl.core)
            );

            assign ctrl_view[g] = ctrl_r;
            assign rel_view[g] = rel_r;
            assign cnt_view[g] = ctl.count;
            assign flag_view[g] = flag_r;
            assign tout_view[g] = ctl.tout;
            assign exp_view[g] = ctl.expire;
        end
    endgenerate

    // =========================================================
    // Read mux, output registers
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr[1:0])
                REG_CTRL: rdata_nxt = ctrl_view[sel];
                REG_COUNT: rdata_nxt = cnt_view[sel];
                REG_RELOAD: rdata_nxt = rel_view[sel];
                REG_STATUS: rdata_nxt = {14'h0000, tout_view[sel], flag_view[sel]};
            endcase
        end
        tout_nxt = tout_view;
        irq_nxt = exp_view;   // Interrupt pulse on each reload
    end

    // Register the outputs
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata_r <= 16'h0000;
            tout_r <= '0;
            irq_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            tout_r <= tout_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign timer_out = tout_r;
    assign timer_irq = irq_r;
endmodule

// ==== core/timer_channel.sv ====
// One 16-bit reload up-counter with prescaler, input edge detect and output.
// Assumes its configuration comes from the register front over timer_ctrl_if.
`timescale 1ns/1ns
module timer_channel
    import reload_timer_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // External input pin
    input wire logic timer_in,
    // Configuration and status
    timer_ctrl_if.core ctl
);
    // =========================================================
    // State
    logic [6:0] pre_r, pre_nxt;        // Prescale divider
    logic [15:0] cnt_r, cnt_nxt;       // Count
    logic sync1_r, sync2_r, prev_r;    // Input synchroniser and history
    logic sync1_nxt, sync2_nxt, prev_nxt;
    logic lvl_r, lvl_nxt;              // Persistent output level
    logic pulse_r, pulse_nxt;          // One-cycle inversion for one-shot
    logic exp_r, exp_nxt;              // Reload event pulse
    logic en_q_r, en_q_nxt;            // Enable seen last cycle
    logic tick, edge_hit, hit;
    logic [6:0] pre_lim;

    // =========================================================
    // Next-state logic
    always_comb begin
        pre_lim = 7'((8'h01 << ctl.pre_sel) - 8'h01);  // Divide by 2^sel: 1..128
        sync1_nxt = timer_in;
        sync2_nxt = sync1_r;
        prev_nxt = sync2_r;
        // Rising edge when pol=1, falling when pol=0
        edge_hit = ctl.pol ? (sync2_r & ~prev_r) : (~sync2_r & prev_r);
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        lvl_nxt = lvl_r;
        pulse_nxt = 1'b0;
        exp_nxt = 1'b0;
        en_q_nxt = ctl.enable;
        tick = 1'b0;
        hit = 1'b0;
        if (!ctl.enable) begin
            pre_nxt = 7'h00;
            lvl_nxt = ctl.pol;                          // Polarity sets start level
        end else if (ctl.mode == MODE_COUNTER) begin
            tick = edge_hit;                            // Prescaler bypassed
        end else begin
            // Clocked modes ignore the pin
            if (pre_r == pre_lim) begin
                pre_nxt = 7'h00;
                tick = 1'b1;
            end else begin
                pre_nxt = pre_r + 7'h01;
            end
        end
        if (tick) begin
            if (cnt_r == ctl.reload) begin
                hit = 1'b1;
            end else begin
                cnt_nxt = cnt_r + COUNT_ONE;            // Wraps FFFF to 0000
            end
        end
        if (hit) begin
            // Reload event: restart at one, later passes ignore start
            cnt_nxt = COUNT_RESTART;
            exp_nxt = 1'b1;                              // Shortest time-out with 0001
            if (ctl.out_en) begin
                if (ctl.mode == MODE_ONE_SHOT) begin
                    pulse_nxt = 1'b1;
                end else begin
                    lvl_nxt = ~lvl_r;
                end
            end
        end
        if (ctl.mode == MODE_ONE_SHOT && ctl.enable && !en_q_r) begin
            lvl_nxt = ctl.pol;                          // Re-take start level at start
        end
        if (ctl.mode == MODE_ONE_SHOT) begin
            lvl_nxt = ctl.pol;                          // One-shot follows polarity bit
        end
        if (ctl.count_wr) begin
            cnt_nxt = ctl.count_wdata;                  // Software start count
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pre_r <= 7'h00;
            cnt_r <= COUNT_RESET;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            lvl_r <= 1'b0;
            pulse_r <= 1'b0;
            exp_r <= 1'b0;
            en_q_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r <= prev_nxt;
            lvl_r <= lvl_nxt;
            pulse_r <= pulse_nxt;
            exp_r <= exp_nxt;
            en_q_r <= en_q_nxt;
        end
    end

    assign ctl.count = cnt_r;
    assign ctl.expire = exp_r;
    assign ctl.tout = lvl_r ^ pulse_r;
endmodule

// ==== inc/reload_timer_pkg.sv ====
// Constants, register map and mode codes for the reload timer block.
// Assumes a single 20 MHz system clock and a plain strobe register port.
package reload_timer_pkg;
    // =========================================================
    // Sizes
    localparam int NUM_TIMERS = 2;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // =========================================================
    // Register map (word indices, per timer block of four)
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_COUNT = 2'h1;
    localparam logic [1:0] REG_RELOAD = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;
    // Timer select is address bit 2
    localparam int TSEL_BIT = 2;
    // =========================================================
    // Control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_POL_BIT = 3;
    localparam int CTRL_OUTEN_BIT = 4;
    localparam int CTRL_PRE_LSB = 5;
    localparam int PRE_W = 3;
    // =========================================================
    // Reset and restart values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESTART = 16'h0001;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    // =========================================================
    // Modes
    typedef enum logic [1:0] {
        MODE_ONE_SHOT = 2'h0,
        MODE_CONTINUOUS = 2'h1,
        MODE_COUNTER = 2'h2
    } timer_mode_e;
endpackage

// ==== inc/timer_ctrl_if.sv ====
// Configuration and status bundle between the register front and one counter.
// Assumes both ends share sys_clk.
`timescale 1ns/1ns
interface timer_ctrl_if;
    import reload_timer_pkg::*;
    logic enable;
    logic [1:0] mode;
    logic pol;
    logic out_en;
    logic [2:0] pre_sel;
    logic [15:0] reload;
    logic count_wr;
    logic [15:0] count_wdata;
    logic [15:0] count;
    logic expire;
    logic tout;
    modport regs (output enable, mode, pol, out_en, pre_sel, reload, count_wr,
        count_wdata, input count, expire, tout);
    modport core (input enable, mode, pol, out_en, pre_sel, reload, count_wr,
        count_wdata, output count, expire, tout);
endinterface

// ==== verification/reload_timer_chk.sv ====
// Port checker for the reload timer block.
// Assumes it is bound to the top module and shares its clock.
`timescale 1ns/1ns
module reload_timer_chk
    import reload_timer_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Pins
    input wire logic [NUM_TIMERS-1:0] timer_out,
    input wire logic [NUM_TIMERS-1:0] timer_irq
);
    // =========
    // Helpers
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic cfg_r; // Any write since reset
    logic cfg_nxt;
    wire st0 = reg_rd && reg_addr[2:0] == 3'h3; // Status read, timer 0
    // Remember the first write
    always_comb cfg_nxt = reset_n & (cfg_r | reg_wr);
    always_ff @(posedge sys_clk) begin
        cfg_r <= cfg_nxt;
    end
    // =========
    // Assertions
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero when idle");
    a_reset_quiet: assert property ($rose(reset_n) |-> timer_out == '0 && timer_irq == '0)
        else $error("outputs active after reset");
    a_idle_unconf: assert property (!cfg_r |-> timer_irq == '0 && timer_out == '0)
        else $error("timer active before any write");
    a_reload_back: assert property (reg_wr && reg_addr[1:0] == 2'h2 ##1 !reg_wr ##1
        reg_rd && reg_addr == $past(reg_addr, 2) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("reload readback wrong");
    a_ctrl_back: assert property (reg_wr && reg_addr[1:0] == 2'h0 ##1 !reg_wr ##1
        reg_rd && reg_addr == $past(reg_addr, 2) |=> reg_rdata[7:1] == $past(reg_wdata[7:1], 3))
        else $error("control readback wrong");
    a_status_lvl: assert property (reg_rd && reg_addr[1:0] == 2'h3 ##1 $stable(timer_out)
        |-> reg_rdata[1] == timer_out[$past(reg_addr[2])])
        else $error("status level differs from pin");
    a_out_cause: assert property ($changed(timer_out[0]) && !$past(reg_wr) &&
        !$past(reg_wr, 2) && !$past(reg_wr, 3) |-> (timer_irq[0] || $past(timer_irq[0])
        || $past(timer_irq[0], 2)) or ##[1:2] timer_irq[0])
        else $error("output moved without reload");
    a_status_sticky: assert property (timer_irq[0] ##1 !st0 ##1 st0 |=> reg_rdata[0])
        else $error("reload flag not held");
    // Main scenarios
    c_irq0: cover property (timer_irq[0]);
    c_irq1: cover property (timer_irq[1]);
    c_flag: cover property (st0 ##1 reg_rdata[0]);
endmodule

// ==== verification/reload_timer_core_test.sv ====
// Self-checking bench for the reload timer block.
// Assumes the checker and pin model files are compiled first.
`timescale 1ns/1ns
module reload_timer_core_test;
    import reload_timer_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    wire [NUM_TIMERS-1:0] timer_in;
    logic [NUM_TIMERS-1:0] timer_out;
    logic [NUM_TIMERS-1:0] timer_irq;
    int errors = 0;
    int checks = 0;
    int cyc = 0; // Cycle count for the hang guard
    int hi0 = 0; // Cycles with output 0 high
    int seed = 95;
    // ==========
    // Clock, hang guard, design and pin sources
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        hi0 <= hi0 + int'(timer_out[0]);
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    reload_timer_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_in(timer_in), .timer_out(timer_out), .timer_irq(timer_irq));
    timer_pin_model pin0 (.sys_clk(sys_clk), .pin(timer_in[0]));
    timer_pin_model pin1 (.sys_clk(sys_clk), .pin(timer_in[1]));
    // ==========
    // Bus tasks and expectations
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Bounded wait; n is the cycle distance to the pulse
    task automatic wait_irq(input int t, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (timer_irq[t] !== 1'b1 && n < 3000);
    endtask
    function automatic logic [3:0] ad(int t, logic [1:0] r);
        return {1'b0, t[0], r};
    endfunction
    function automatic logic [15:0] ctl(int md, int pl, int oe, int pe, int en);
        return 16'((pe << CTRL_PRE_LSB) | (oe << CTRL_OUTEN_BIT) | (pl << CTRL_POL_BIT)
            | (md << CTRL_MODE_LSB) | en);
    endfunction
    task automatic end_sim();
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ==========
    // Scenarios
    initial begin
        logic [15:0] d, st, rl;
        int n, pe, h, e;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(4'(i), d);
            chk(d, 16'h0000);
        end
        // One-shot: wrap from fffe, then the shortest case
        for (int i = 0; i < 2; i++) begin
            st = i ? 16'h0000 : 16'hfffe;
            rl = i ? COUNT_ONE : 16'h0003;
            pe = i ? 0 : $unsigned($random(seed)) % 3;
            wr(ad(0, REG_CTRL), ctl(0, 0, 1, pe, 0));
            wr(ad(0, REG_COUNT), st);
            wr(ad(0, REG_RELOAD), rl);
            rd(ad(0, REG_RELOAD) | 4'h8, d);
            chk(d, rl);
            h = hi0;
            wr(ad(0, REG_CTRL), ctl(0, 0, 1, pe, 1));
            wait_irq(0, n);
            e = int'(16'(rl - st)) << pe;
            chk(16'(n >= e && n <= e + (1 << pe) + 6), 16'h1);
            rd(ad(0, REG_STATUS), d);
            chk(d & 16'h1, 16'h1);
            rd(ad(0, REG_COUNT), d);
            chk(d, COUNT_RESTART);
            rd(ad(0, REG_CTRL), d);
            chk(d, ctl(0, 0, 1, pe, 0));
            chk(16'(hi0 - h), 16'h1);
        end
        // Lasting one-shot output change: start low, flip polarity once running
        wr(ad(0, REG_CTRL), ctl(0, 0, 1, 0, 0));
        wr(ad(0, REG_COUNT), COUNT_ONE);
        wr(ad(0, REG_RELOAD), 16'h0020);
        wr(ad(0, REG_CTRL), ctl(0, 0, 1, 0, 1));
        wr(ad(0, REG_CTRL), ctl(0, 1, 1, 0, 1));
        wait_irq(0, n);
        chk({15'h0, timer_out[0]}, 16'h0);
        repeat (3) @(posedge sys_clk);
        chk({15'h0, timer_out[0]}, 16'h1);
        // Continuous on timer 1 while its input pin toggles
        pe = $unsigned($random(seed)) % 3;
        rl = 16'(3 + $unsigned($random(seed)) % 8);
        st = 16'(1 + $unsigned($random(seed)) % 2);
        wr(ad(1, REG_CTRL), ctl(1, 1, 1, pe, 0));
        wr(ad(1, REG_COUNT), st);
        wr(ad(1, REG_RELOAD), rl);
        rd(ad(1, REG_RELOAD), d);
        chk({15'h0, timer_out[1]}, 16'h1);
        wr(ad(1, REG_CTRL), ctl(1, 1, 1, pe, 1));
        fork
            pin1.pulses(8);
        join_none
        wait_irq(1, n);
        e = int'(16'(rl - st)) << pe;
        chk(16'(n >= e && n <= e + (1 << pe) + 6), 16'h1);
        for (int k = 0; k < 3; k++) begin
            wait_irq(1, n);
            chk(16'(n), 16'(int'(rl) << pe));
            chk({15'h0, timer_out[1]}, 16'((k + 1) % 2));
        end
        wr(ad(1, REG_CTRL), ctl(1, 1, 1, pe, 0));
        // Counter mode with the largest prescale, both edge senses
        for (int p = 0; p < 2; p++) begin
            wr(ad(0, REG_CTRL), ctl(2, p, 0, 7, 0));
            rd(ad(0, REG_CTRL), d);
            chk({15'h0, timer_out[0]}, 16'(p));
            wr(ad(0, REG_COUNT), COUNT_ONE);
            wr(ad(0, REG_RELOAD), 16'h0004);
            wr(ad(0, REG_CTRL), ctl(2, p, 0, 7, 1));
            pin0.pulses(2);
            repeat (6) @(posedge sys_clk);
            rd(ad(0, REG_COUNT), d);
            chk(d, 16'h0003);
            fork
                pin0.pulses(2);
            join_none
            wait_irq(0, n);
            chk(16'(n < 40), 16'h1);
            rd(ad(0, REG_COUNT), d);
            chk(d, COUNT_RESTART);
            wr(ad(0, REG_CTRL), ctl(2, p, 0, 7, 0));
        end
        end_sim();
    end
endmodule
bind reload_timer_core reload_timer_chk chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_out(timer_out), .timer_irq(timer_irq));

// ==== verification/timer_pin_model.sv ====
// External source driving one timer input pin.
// Assumes the bench calls pulses from its own thread.
`timescale 1ns/1ns
module timer_pin_model (
    // Clock
    input wire logic sys_clk,
    // Pin
    output logic pin
);
    initial pin = 1'b0;
    // Each level lasts four clocks, so transitions stay at a quarter of sys_clk
    task automatic pulses(input int n);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge sys_clk);
            pin <= ~pin;
            repeat (3) @(posedge sys_clk);
        end
    endtask
endmodule
